// >>> src/codec_port_pkg.sv
package codec_port_pkg;
  // Register word indices (word index in haddr[6:2])
  localparam logic [4:0] TX_DATA_IDX = 5'h00;
  localparam logic [4:0] RX_DATA_IDX = 5'h01;
  localparam logic [4:0] LEVEL_IDX = 5'h02;
  localparam logic [4:0] CONTROL_IDX = 5'h03;
  localparam logic [4:0] STATUS_IDX = 5'h04;
  localparam logic [4:0] ALERT_CTRL_IDX = 5'h05;
  // Control register fields
  localparam int CTL_POWER = 7;
  localparam int CTL_LOOP = 6;
  localparam int CTL_ENABLE = 5;
  localparam int CTL_SELECT = 4;
  localparam int CTL_RELAY = 3;
  localparam int CTL_RING_IE = 2;
  localparam int CTL_EMPTY_IE = 1;
  localparam int CTL_ERR_IE = 0;
  // Status register fields
  localparam int ST_RING = 2;
  localparam int ST_EMPTY = 1;
  localparam int ST_ERR = 0;
  // Level register fields
  localparam int LV_ALERT = 10;
  localparam int LV_TX_FULL = 9;
  localparam int LV_RING = 8;
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic ALERT_CTRL_RST = 1'b1;
  // Serial framing
  localparam int WORD_BITS = 16;
  localparam int FIFO_BYTES = 32;
  localparam int BIT_CLK_KHZ = 864;
  localparam int DATA_RATE_KBPS = 56;
endpackage : codec_port_pkg

// >>> src/telephony_codec_serial_port.sv
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module telephony_codec_serial_port
  import codec_port_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_BYTES * 8 / WORD_BITS
) (
  // System
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Codec link
  input wire logic codec_bit_clk,
  input wire logic codec_frame_sync,
  input wire logic codec_serial_in,
  output logic codec_serial_out,
  output logic control_data_select_n,
  // Line interface
  input wire logic ring_in,
  output logic relay_drive_out,
  output logic serial_port_alert_out,
  output logic front_end_irq
);
  localparam int PW = $clog2(FIFO_WORDS);
  localparam logic [PW:0] DEPTH = (PW+1)'(FIFO_WORDS);

  // every codec and line input pin passes two flops
  localparam int N_PINS = 4;
  wire [N_PINS-1:0] pin_raw = {ring_in, codec_serial_in, codec_frame_sync,
    codec_bit_clk};
  wire [N_PINS-1:0] pin_sync;
  for (genvar p = 0; p < N_PINS; p++) begin : g_sync
    logic [1:0] sync_r;
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        sync_r <= 2'h0;
      end else begin
        sync_r <= {sync_r[0], pin_raw[p]};
      end
    end
    assign pin_sync[p] = sync_r[1];
  end
  wire clk_s = pin_sync[0];
  wire fs_s = pin_sync[1];
  wire sdi_s = pin_sync[2];
  wire ring_s = pin_sync[3];

  // Bit clock edges, seen two cycles late; the flop starts low, the idle
  // level of the codec clock, so leaving reset makes no false edge
  logic clk_d_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= clk_s;
    end
  end
  wire bit_rise = clk_s & ~clk_d_r;
  wire bit_fall = ~clk_s & clk_d_r;

  // Bus address phase capture
  logic wr_pend_r, rd_pend_r;
  logic [4:0] idx_r;
  wire take = hsel & hready & htrans[1];
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r <= 5'h00;
    end else begin
      wr_pend_r <= take & hwrite;
      rd_pend_r <= take & ~hwrite;
      if (take) idx_r <= haddr[6:2];
    end
  end
  // Zero wait states: every data phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Control registers
  logic [7:0] ctrl_r;
  logic alert_ctrl_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= CONTROL_RST;
      alert_ctrl_r <= ALERT_CTRL_RST;
    end else if (wr_pend_r) begin
      if (idx_r == CONTROL_IDX) ctrl_r <= hwdata[7:0];
      if (idx_r == ALERT_CTRL_IDX) alert_ctrl_r <= hwdata[0];
    end
  end
  wire enable = ctrl_r[CTL_ENABLE];
  wire running = enable & ctrl_r[CTL_POWER];

  logic [WORD_BITS-1:0] tx_mem [FIFO_WORDS];
  logic [WORD_BITS-1:0] rx_mem [FIFO_WORDS];
  logic [PW:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  wire [PW:0] tx_cnt = tx_wp_r - tx_rp_r;
  wire [PW:0] rx_cnt = rx_wp_r - rx_rp_r;
  wire tx_empty = (tx_cnt == '0);
  wire tx_full = (tx_cnt == DEPTH);
  wire rx_empty = (rx_cnt == '0);
  wire rx_full = (rx_cnt == DEPTH);

  // Serial engine
  logic [WORD_BITS-1:0] tx_sh_r, rx_sh_r;
  logic [4:0] bit_cnt_r;
  logic active_r, tx_pop, rx_push, slot_err;
  wire sdi_bit = ctrl_r[CTL_LOOP] ? codec_serial_out : sdi_s;
  wire slot_start = running & bit_rise & fs_s;
  // one 16-bit word per frame slot
  wire last_rise = active_r & bit_rise & (bit_cnt_r == 5'(WORD_BITS-1));
  // Slot closes on the fall after the last rise, so the last bit
  // still stands when the codec takes it
  wire last_fall = active_r & bit_fall & (bit_cnt_r == 5'(WORD_BITS));

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !running) begin
      active_r <= 1'b0;
    end else if (slot_start) begin
      active_r <= 1'b1;
    end else if (last_fall) begin
      active_r <= 1'b0;
    end
  end

  // Bit position inside the slot, 1 after the frame edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !running) begin
      bit_cnt_r <= 5'h00;
    end else if (slot_start) begin
      bit_cnt_r <= 5'h01;
    end else if (active_r && bit_rise) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !running) begin
      tx_sh_r <= '0;
    end else if (slot_start) begin
      tx_sh_r <= tx_empty ? '0 : tx_mem[tx_rp_r[PW-1:0]];
    end else if (active_r && bit_fall && !last_fall) begin
      tx_sh_r <= {tx_sh_r[WORD_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !running) begin
      rx_sh_r <= '0;
    end else if (slot_start || (active_r && bit_rise)) begin
      rx_sh_r <= {rx_sh_r[WORD_BITS-2:0], sdi_bit};
    end
  end

  assign tx_pop = slot_start & ~tx_empty;
  assign slot_err = slot_start & tx_empty;
  assign rx_push = last_rise & ~rx_full;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) codec_serial_out <= 1'b0;
    else codec_serial_out <= enable & active_r & tx_sh_r[WORD_BITS-1];
  end

  // FIFO pointers; disabled FIFOs flush
  wire tx_wr = wr_pend_r & (idx_r == TX_DATA_IDX) & enable & ~tx_full;
  wire rx_rd = rd_pend_r & (idx_r == RX_DATA_IDX) & ~rx_empty;
  // Dropping enable empties both FIFOs, so no stale word
  // leaks into the next session
  wire flush = !rst_n || !enable;
  always_ff @(posedge sys_clk) begin
    if (flush) begin
      tx_wp_r <= '0;
    end else if (tx_wr) begin
      tx_wp_r <= tx_wp_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flush) begin
      tx_rp_r <= '0;
    end else if (tx_pop) begin
      tx_rp_r <= tx_rp_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flush) begin
      rx_wp_r <= '0;
    end else if (rx_push) begin
      rx_wp_r <= rx_wp_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flush) begin
      rx_rp_r <= '0;
    end else if (rx_rd) begin
      rx_rp_r <= rx_rp_r + 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (tx_wr) tx_mem[tx_wp_r[PW-1:0]] <= hwdata[WORD_BITS-1:0];
    if (rx_push) rx_mem[rx_wp_r[PW-1:0]] <= {rx_sh_r[WORD_BITS-2:0], sdi_bit};
  end

  // Sticky status, set beats read-clear
  wire [2:0] status_r;
  logic tx_empty_d_r;
  wire st_rd = rd_pend_r & (idx_r == STATUS_IDX);
  wire rx_overflow = last_rise & rx_full;
  // A write into a full transmit FIFO is lost and counts as an error
  wire tx_drop = wr_pend_r & (idx_r == TX_DATA_IDX) & enable & tx_full;
  logic [2:0] ev;
  logic [2:0] irq_en;
  always_comb begin
    ev = 3'h0;
    ev[ST_RING] = ring_s;
    ev[ST_EMPTY] = tx_empty & ~tx_empty_d_r;
    ev[ST_ERR] = slot_err | rx_overflow | tx_drop;
  end
  always_comb begin
    irq_en = 3'h0;
    irq_en[ST_RING] = ctrl_r[CTL_RING_IE];
    irq_en[ST_EMPTY] = ctrl_r[CTL_EMPTY_IE];
    irq_en[ST_ERR] = ctrl_r[CTL_ERR_IE];
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      tx_empty_d_r <= 1'b1;
    end else begin
      tx_empty_d_r <= tx_empty;
    end
  end
  // one flag per source; a read clears, a new event wins
  for (genvar s = 0; s < 3; s++) begin : g_status
    logic flag_r;
    always_ff @(posedge sys_clk) begin
      if (!rst_n || !enable) begin
        flag_r <= 1'b0;
      end else if (ev[s]) begin
        flag_r <= 1'b1;
      end else if (st_rd) begin
        flag_r <= 1'b0;
      end
    end
    assign status_r[s] = flag_r;
  end

  wire [2:0] irq_src = status_r & irq_en;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) front_end_irq <= 1'b0;
    else front_end_irq <= enable & |irq_src;
  end

  // ring toward serial port, high while alert_ctrl_r is set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_port_alert_out <= 1'b1;
    end else begin
      serial_port_alert_out <= alert_ctrl_r | ~ring_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      relay_drive_out <= 1'b0;
    end else begin
      relay_drive_out <= ctrl_r[CTL_RELAY];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      control_data_select_n <= 1'b1;
    end else begin
      control_data_select_n <= ~ctrl_r[CTL_SELECT];
    end
  end

  // read mux, zero when not reading
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    case (idx_r)
      RX_DATA_IDX: rd_val[WORD_BITS-1:0] = rx_empty ? '0 :
                                           rx_mem[rx_rp_r[PW-1:0]];
      LEVEL_IDX: begin
        rd_val[LV_ALERT] = serial_port_alert_out;
        rd_val[LV_TX_FULL] = tx_full;
        rd_val[LV_RING] = ring_s;
        rd_val[7:4] = 4'(tx_cnt);
        rd_val[3:0] = 4'(rx_cnt);
      end
      CONTROL_IDX: rd_val[7:0] = ctrl_r;
      STATUS_IDX: rd_val[2:0] = status_r;
      ALERT_CTRL_IDX: rd_val[0] = alert_ctrl_r;
      default: rd_val = 32'h0;
    endcase
  end
  assign hrdata = rd_pend_r ? rd_val : 32'h0;
endmodule : telephony_codec_serial_port

// >>> tb/codec_port_chk.sv
`timescale 1ns/1ps
module codec_port_chk
  import codec_port_pkg::*;
(
  // System
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic codec_serial_out,
  input wire logic control_data_select_n,
  input wire logic relay_drive_out,
  input wire logic serial_port_alert_out,
  input wire logic front_end_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd_r;
  logic [4:0] ix_r;
  always_ff @(posedge sys_clk) begin
    rd_r <= rst_n && hsel && hready && htrans[1] && !hwrite;
    ix_r <= haddr[6:2];
  end
  a_rdata_idle: assert property (!rd_r |-> hrdata == 32'h0)
    else $error("hrdata driven outside a read");
  a_rx_half: assert property (rd_r && ix_r == RX_DATA_IDX |->
    hrdata[31:16] == 16'h0) else $error("rx upper half not zero");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave answer not ready okay");
  a_out_reset: assert property ($rose(rst_n) |-> !codec_serial_out)
    else $error("serial out high after reset");
  a_irq_reset: assert property ($rose(rst_n) |-> !front_end_irq)
    else $error("irq high after reset");
  a_alert_reset: assert property ($rose(rst_n) |-> serial_port_alert_out)
    else $error("alert low after reset");
  a_select_reset: assert property ($rose(rst_n) |-> control_data_select_n)
    else $error("select low after reset");
  a_relay_reset: assert property ($rose(rst_n) |-> !relay_drive_out)
    else $error("relay high after reset");
  cover property (rd_r && ix_r == RX_DATA_IDX);
  cover property ($rose(front_end_irq));
  cover property ($fell(serial_port_alert_out));
endmodule : codec_port_chk
bind telephony_codec_serial_port codec_port_chk chk_i (.*);

// >>> tb/codec_partner.sv
`timescale 1ns/1ps
module codec_partner (
  // Bench control
  input wire logic go,
  input wire logic [15:0] send_word,
  // Codec pins
  output logic codec_bit_clk,
  output logic codec_frame_sync,
  output logic codec_serial_in,
  input wire logic codec_serial_out,
  output logic [15:0] heard_word
);
  initial begin
    codec_bit_clk = 1'b0;
    codec_frame_sync = 1'b0;
    codec_serial_in = 1'b0;
    heard_word = 16'h0;
  end
  // clock runs only inside a slot
  always @(posedge go) begin
    #7;
    for (int i = 15; i >= 0; i--) begin
      codec_serial_in = send_word[i];
      codec_frame_sync = (i == 15);
      #80 codec_bit_clk = 1'b1;
      #80 codec_bit_clk = 1'b0;
      heard_word[i] = codec_serial_out;
      codec_frame_sync = 1'b0;
    end
    // Released line must not show a stale bit
    codec_serial_in = ~codec_serial_in;
  end
endmodule : codec_partner

// >>> tb/telephony_codec_serial_port_bench.sv
`timescale 1ns/1ps
module telephony_codec_serial_port_bench;
  import codec_port_pkg::*;
  logic sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, go;
  logic codec_bit_clk, codec_frame_sync, codec_serial_in, codec_serial_out;
  logic control_data_select_n, ring_in, relay_drive_out;
  logic serial_port_alert_out, front_end_irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] send_word, heard_word;
  int n_mismatch, n_compared;
  telephony_codec_serial_port uut (.*);
  codec_partner far (.*);
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    n_compared++;
    if (v !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic hold();
    int k;
    k = 0;
    do begin
      @(negedge sys_clk) rd = hrdata;
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask : hold
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    hold();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hold();
  endtask : bus
  task automatic wr(logic [4:0] i, logic [31:0] d);
    bus(1'b1, {1'b0, i, 2'b00}, d);
  endtask : wr
  task automatic rdchk(string s, logic [4:0] i, logic [31:0] e);
    bus(1'b0, {1'b0, i, 2'b00}, 32'h0);
    chk(s, e, rd);
  endtask : rdchk
  task automatic frame(logic [15:0] w);
    send_word <= w;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (140) @(posedge sys_clk);
  endtask : frame
  task automatic t_reset();
    chk("pins", 32'h18, 32'({serial_port_alert_out, control_data_select_n,
      relay_drive_out, codec_serial_out, front_end_irq}));
    rdchk("control", CONTROL_IDX, 32'(CONTROL_RST));
    rdchk("alert_ctrl", ALERT_CTRL_IDX, 32'(ALERT_CTRL_RST));
  endtask : t_reset
  task automatic t_regs();
    // Address bit 7 set must alias onto the same slot
    bus(1'b1, {1'b1, CONTROL_IDX, 2'b00}, 32'h18);
    rdchk("control", CONTROL_IDX, 32'h18);
    chk("select_n", 32'h0, 32'(control_data_select_n));
    chk("relay", 32'h1, 32'(relay_drive_out));
    rdchk("unmapped", ALERT_CTRL_IDX + 5'h1, 32'h0);
  endtask : t_regs
  task automatic t_xfer();
    wr(CONTROL_IDX, 32'ha3);
    wr(TX_DATA_IDX, 32'hb38d);
    rdchk("level", LEVEL_IDX, 32'h410);
    frame(16'h5a3c);
    chk("sent", 32'hb38d, 32'(heard_word));
    chk("irq", 32'h1, 32'(front_end_irq));
    rdchk("status", STATUS_IDX, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0, 32'(front_end_irq));
    rdchk("rx", RX_DATA_IDX, 32'h5a3c);
    frame(16'h0f0f);
    chk("sent", 32'h0, 32'(heard_word));
    bus(1'b0, {1'b0, STATUS_IDX, 2'b00}, 32'h0);
    chk("error", 32'h1, 32'(rd[ST_ERR]));
    rdchk("rx", RX_DATA_IDX, 32'h0f0f);
  endtask : t_xfer
  task automatic t_ring();
    wr(CONTROL_IDX, 32'ha4);
    wr(ALERT_CTRL_IDX, 32'h0);
    ring_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("ring", 32'h2, 32'({front_end_irq, serial_port_alert_out}));
    ring_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rdchk("status", STATUS_IDX, 32'h4);
  endtask : t_ring
  task automatic t_off();
    wr(TX_DATA_IDX, 32'h8001);
    wr(CONTROL_IDX, 32'h80);
    frame(16'hffff);
    chk("sent", 32'h0, 32'(heard_word));
    rdchk("level", LEVEL_IDX, 32'h400);
    chk("irq", 32'h0, 32'(front_end_irq));
  endtask : t_off
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, ring_in, go} = '0;
    {hready, hsize, send_word} = {1'b1, 3'h2, 16'h0};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_xfer();
    t_ring();
    t_off();
    results();
  end
endmodule : telephony_codec_serial_port_bench
